// ---- bench/flash_status_dev.sv ----
// Behavioural flash status model answering the host's polling reads.
`timescale 1ns/1ns
module flash_status_dev (
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic [15:0] i_dq,
  output logic      [15:0] o_dq,
  output logic             o_rb_low
);
  int          left    = 0;
  int          n_reset = 0;
  logic        fail    = 1'b0;
  logic        susp    = 1'b0;
  logic        tog     = 1'b0;
  logic        tog2    = 1'b0;
  logic        done;
  logic [15:0] stat;
  wire         rd_on = !i_ce_n && !i_oe_n;
  assign done = (left == 0 && !fail) || susp;
  assign stat = {8'h00, done, tog, fail, 1'b0, 1'b1, tog2, 2'b00};
  // A released bus shows the inverse so a stale value can never pass for status.
  assign o_dq = rd_on ? stat : ~stat;
  assign o_rb_low = (left != 0 || fail) && !susp;
  always @(posedge rd_on) begin
    if (susp) begin
      tog2 = ~tog2;
    end else if (left != 0 || fail) begin
      tog = ~tog;
      tog2 = ~tog2;
      if (left != 0) left = left - 1;
    end
  end
  // Only the reset byte is decoded; every other write is ignored.
  always @(posedge i_we_n) begin
    if (i_dq[7:0] == 8'hF0) begin
      left = 0;
      fail = 1'b0;
      susp = 1'b0;
      n_reset = n_reset + 1;
    end
  end
  // A finite count stands for an operation that ends by itself, as on a protected target.
  task start(input int n, input logic f, input logic s);
    left = n;
    fail = f;
    susp = s;
  endtask : start
endmodule : flash_status_dev

// ---- bench/flash_status_host_chk.sv ----
// Checker for the polling host's register port and flash strobe timing.
`timescale 1ns/1ns
module flash_status_host_chk (
  input wire logic        i_clock,
  input wire logic        i_srst,
  input wire logic [3:0]  i_sw_addr,
  input wire logic [31:0] i_sw_wdata,
  input wire logic        i_sw_wr,
  input wire logic        i_sw_rd,
  input wire logic [31:0] o_sw_rdata,
  input wire logic [19:0] o_flash_addr,
  input wire logic [15:0] o_flash_dq,
  input wire logic        o_flash_dq_oe,
  input wire logic        o_flash_ce_n,
  input wire logic        o_flash_oe_n,
  input wire logic        o_flash_we_n,
  input wire logic        o_busy
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  sequence s_read;
    !o_flash_oe_n [*6] ##1 o_flash_oe_n [*2];
  endsequence
  sequence s_write;
    !o_flash_we_n [*6] ##1 o_flash_we_n;
  endsequence
  a_read_pulse: assert property ($fell(o_flash_oe_n) |-> s_read)
    else $error("read strobe length wrong");
  a_write_pulse: assert property ($fell(o_flash_we_n) |-> s_write)
    else $error("write strobe length wrong");
  a_reset_cmd: assert property (!o_flash_we_n |-> o_flash_dq_oe && o_flash_dq == 16'h00F0
    && o_flash_addr == 20'h00000) else $error("write is not the reset command");
  a_read_float: assert property (!o_flash_oe_n |-> !o_flash_ce_n && !o_flash_dq_oe)
    else $error("read without select or with bus driven");
  a_one_strobe: assert property (o_flash_oe_n || o_flash_we_n)
    else $error("read and write strobes together");
  a_rdata_idle: assert property (!i_sw_rd |=> o_sw_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_start_busy: assert property (i_sw_wr && i_sw_addr == 4'h0 && i_sw_wdata[0] && !o_busy
    |-> ##[1:2] o_busy) else $error("start did not raise busy");
  a_reset_quiet: assert property ($fell(i_srst) |-> o_flash_ce_n && o_flash_oe_n
    && o_flash_we_n && !o_busy) else $error("outputs not idle after reset");
  a_done_quiet: assert property ($fell(o_busy) |-> o_flash_ce_n && o_flash_we_n)
    else $error("flash access still open when idle");
endmodule : flash_status_host_chk
bind flash_status_host flash_status_host_chk flash_status_host_chk_inst (.*);

// ---- bench/tb_top.sv ----
// Self-checking bench for the flash status polling host controller.
`timescale 1ns/1ns
module tb_top;
  logic        i_clock  = 1'b0;
  logic        i_srst   = 1'b1;
  logic [3:0]  sw_addr  = 4'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic        sw_wr    = 1'b0;
  logic        sw_rd    = 1'b0;
  logic [31:0] d;
  wire  [31:0] sw_rdata;
  wire  [19:0] f_addr;
  wire  [15:0] dq_h, dq_d;
  wire         dq_oe, ce_n, oe_n, we_n, rb_low, busy;
  wire         rb_n = rb_low ? 1'b0 : 1'b1;
  int          n_fail = 0;
  int          n_compared = 0;
  always #10 i_clock = ~i_clock;
  flash_status_host flash_status_host_inst (.i_clock(i_clock), .i_srst(i_srst),
    .i_sw_addr(sw_addr), .i_sw_wdata(sw_wdata), .i_sw_wr(sw_wr), .i_sw_rd(sw_rd),
    .o_sw_rdata(sw_rdata), .o_flash_addr(f_addr), .o_flash_dq(dq_h), .o_flash_dq_oe(dq_oe),
    .i_flash_dq(dq_d), .o_flash_ce_n(ce_n), .o_flash_oe_n(oe_n), .o_flash_we_n(we_n),
    .i_ready_busy_n(rb_n), .o_busy(busy));
  flash_status_dev flash_status_dev_inst (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
    .i_dq(dq_h), .o_dq(dq_d), .o_rb_low(rb_low));
  task results;
    if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_clock);
    sw_addr <= a;
    sw_wdata <= v;
    sw_wr <= 1'b1;
    @(posedge i_clock);
    sw_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a);
    @(posedge i_clock);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge i_clock);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask : rd
  // Bounded so a stuck engine ends the run instead of hanging it.
  task poll(input int n, input logic f, input logic s, input logic ab, input logic [3:0] exp,
            input int resets, input logic [7:0] last);
    int r0;
    r0 = flash_status_dev_inst.n_reset;
    flash_status_dev_inst.start(n, f, s);
    wr(flash_status_host_pkg::REG_CTRL, 32'h1);
    if (ab) wr(flash_status_host_pkg::REG_CTRL, 32'h2);
    repeat (3) @(posedge i_clock);
    chk("flash address", 32'h00012345, {12'h000, f_addr});
    chk("read strobes", 32'h0, {30'h0, ce_n, oe_n});
    for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(posedge i_clock);
    chk("engine idle", 32'h0, {31'h0, busy});
    if (busy !== 1'b0) results();
    rd(flash_status_host_pkg::REG_STATUS);
    chk("status", {28'h0, exp}, {28'h0, d[3:0]});
    chk("reset commands", resets, flash_status_dev_inst.n_reset - r0);
    rd(flash_status_host_pkg::REG_LAST);
    chk("last status", {24'h0, last}, {24'h0, d[7:0] & 8'hB8});
  endtask : poll
  task sc_regs;
    rd(flash_status_host_pkg::REG_TOUT);
    chk("timeout reset", 32'h000F4240, d);
    rd(4'hF);
    chk("unmapped", 32'h0, d);
    wr(flash_status_host_pkg::REG_TOUT, 32'h000000C8);
    wr(flash_status_host_pkg::REG_ADDR, 32'h00012345);
    rd(flash_status_host_pkg::REG_TOUT);
    chk("timeout limit", 32'h000000C8, d);
    rd(flash_status_host_pkg::REG_ADDR);
    chk("poll address", 32'h00012345, d);
  endtask : sc_regs
  task sc_done;
    poll(0, 1'b0, 1'b0, 1'b0, 4'hE, 0, 8'h88);
    poll(3, 1'b0, 1'b0, 1'b0, 4'hE, 0, 8'h88);
  endtask : sc_done
  task sc_fail;
    poll(100000, 1'b1, 1'b0, 1'b0, 4'hF, 1, 8'h28);
  endtask : sc_fail
  task sc_tout;
    poll(100000, 1'b0, 1'b0, 1'b0, 4'hF, 1, 8'h08);
  endtask : sc_tout
  task sc_abort;
    poll(100000, 1'b0, 1'b0, 1'b1, 4'h4, 0, 8'h08);
  endtask : sc_abort
  task sc_suspend;
    poll(5, 1'b0, 1'b1, 1'b0, 4'hE, 0, 8'h88);
  endtask : sc_suspend
  task sc_resume;
    poll(2, 1'b0, 1'b0, 1'b0, 4'hE, 0, 8'h88);
  endtask : sc_resume
  initial begin
    repeat (3) @(posedge i_clock);
    i_srst <= 1'b0;
    sc_regs();
    sc_done();
    sc_fail();
    sc_tout();
    sc_abort();
    sc_suspend();
    sc_resume();
    results();
  end
endmodule : tb_top

// ---- design/flash_status_host.sv ----
// Host controller that polls flash toggle status and recovers from timeout failures.
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
// Summary of operation
// - Host reads twice in a row and compares toggle bits; equal means done.
// - If toggling with timeout bit set, recheck; still toggling means fail and reset.
// - Polling that was abandoned restarts from its first double read.
// - After any timeout failure the host writes the reset command.
// - Erase timer check may be skipped only with sector commands under 50 us apart; this host sends no sector commands and leaves ERASE_GAP_CYC unused.
// - Check erase timer before and after each added sector erase command; this host only latches the ERASE_TIMER_POS bit in ST_CHECK, not at the ST_READ4 recheck.
module flash_status_host (
  input  wire logic                                       i_clock,
  input  wire logic                                       i_srst,
  input  wire logic [flash_status_host_pkg::SW_ADDR_W-1:0] i_sw_addr,
  input  wire logic [31:0]                                i_sw_wdata,
  input  wire logic                                       i_sw_wr,
  input  wire logic                                       i_sw_rd,
  output logic      [31:0]                                o_sw_rdata,
  output logic      [flash_status_host_pkg::ADDR_W-1:0]    o_flash_addr,
  output logic      [flash_status_host_pkg::DATA_W-1:0]    o_flash_dq,
  output logic                                            o_flash_dq_oe,
  input  wire logic [flash_status_host_pkg::DATA_W-1:0]    i_flash_dq,
  output logic                                            o_flash_ce_n,
  output logic                                            o_flash_oe_n,
  output logic                                            o_flash_we_n,
  input  wire logic                                       i_ready_busy_n,
  output logic                                            o_busy
);
  localparam int unsigned AW = flash_status_host_pkg::ADDR_W;
  localparam int unsigned DW = flash_status_host_pkg::DATA_W;

  flash_status_host_pkg::poll_state_e state_r;
  logic [AW-1:0] poll_addr_r;
  logic [DW-1:0] first_r;
  logic [DW-1:0] last_r;
  logic [1:0]    result_r;
  logic          erase_timer_r;
  logic          ready_r;
  logic [31:0]   tout_lim_r;
  logic [31:0]   tout_cnt_r;
  logic [3:0]    acc_cnt_r;
  logic          acc_done;
  logic          start;
  logic          abort;
  logic          abort_r;
  logic          tout_hit;

  function automatic logic tog_differs(input logic [DW-1:0] a, input logic [DW-1:0] b);
    tog_differs = a[flash_status_host_pkg::TOGGLE_POS] != b[flash_status_host_pkg::TOGGLE_POS];
  endfunction : tog_differs

  assign start    = i_sw_wr && (i_sw_addr == flash_status_host_pkg::REG_CTRL) && i_sw_wdata[0];
  assign abort    = i_sw_wr && (i_sw_addr == flash_status_host_pkg::REG_CTRL) && i_sw_wdata[1];
  assign acc_done = (acc_cnt_r ==
                     4'(flash_status_host_pkg::ACC_CYC + flash_status_host_pkg::GAP_CYC));
  assign tout_hit = (tout_cnt_r >= tout_lim_r);

  // Software configuration registers.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      poll_addr_r <= '0;
      tout_lim_r  <= 32'(flash_status_host_pkg::TOUT_DEFAULT_US * flash_status_host_pkg::CLK_MHZ);
    end else if (i_sw_wr && state_r == flash_status_host_pkg::ST_IDLE) begin
      if (i_sw_addr == flash_status_host_pkg::REG_ADDR) begin
        poll_addr_r <= i_sw_wdata[AW-1:0];
      end else if (i_sw_addr == flash_status_host_pkg::REG_TOUT) begin
        tout_lim_r <= i_sw_wdata;
      end
    end
  end

  // Ready/busy is sampled only; the pin is open drain and belongs to the flash.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= i_ready_busy_n;
    end
  end

  // Bus cycle timer: strobes low for ACC_CYC, then a gap so each read is a separate cycle.
  always_ff @(posedge i_clock) begin
    if (i_srst || state_r == flash_status_host_pkg::ST_IDLE ||
        state_r == flash_status_host_pkg::ST_CHECK ||
        state_r == flash_status_host_pkg::ST_FINISH || acc_done) begin
      acc_cnt_r <= '0;
    end else begin
      acc_cnt_r <= acc_cnt_r + 4'h1;
    end
  end

  // Overall polling timeout.
  always_ff @(posedge i_clock) begin
    if (i_srst || state_r == flash_status_host_pkg::ST_IDLE) begin
      tout_cnt_r <= '0;
    end else if (!tout_hit) begin
      tout_cnt_r <= tout_cnt_r + 32'h1;
    end
  end

  // Abort written while not idle is held and acted on only at the end of a first read (ST_READ1), so no flash strobe is ever cut short.
  always_ff @(posedge i_clock) begin
    if (i_srst || state_r == flash_status_host_pkg::ST_IDLE) begin
      abort_r <= 1'b0;
    end else if (abort) begin
      abort_r <= 1'b1;
    end
  end

  // Polling state machine.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_r       <= flash_status_host_pkg::ST_IDLE;
      first_r       <= '0;
      last_r        <= '0;
      result_r      <= flash_status_host_pkg::RES_IDLE;
      erase_timer_r <= 1'b0;
    end else begin
      case (state_r)
        flash_status_host_pkg::ST_IDLE: begin
          if (start) begin
            state_r  <= flash_status_host_pkg::ST_READ1; // always restart with a double read
            result_r <= flash_status_host_pkg::RES_BUSY;
          end
        end
        flash_status_host_pkg::ST_READ1: begin
          if (acc_done) begin
            if (abort_r) begin
              state_r <= flash_status_host_pkg::ST_FINISH;
            end else begin
              first_r <= last_r;
              state_r <= flash_status_host_pkg::ST_READ2;
            end
          end
        end
        flash_status_host_pkg::ST_READ2: begin
          if (acc_done) begin
            state_r <= flash_status_host_pkg::ST_CHECK;
          end
        end
        flash_status_host_pkg::ST_CHECK: begin
          erase_timer_r <= last_r[flash_status_host_pkg::ERASE_TIMER_POS];
          if (!tog_differs(first_r, last_r)) begin
            result_r <= flash_status_host_pkg::RES_DONE;
            state_r  <= flash_status_host_pkg::ST_FINISH;
          end else if (last_r[flash_status_host_pkg::TIMEOUT_POS]) begin
            state_r <= flash_status_host_pkg::ST_READ3;
          end else if (tout_hit) begin
            state_r <= flash_status_host_pkg::ST_RESET;
          end else begin
            state_r <= flash_status_host_pkg::ST_READ1;
          end
        end
        flash_status_host_pkg::ST_READ3: begin
          if (acc_done) begin
            first_r <= last_r;
            state_r <= flash_status_host_pkg::ST_READ4;
          end
        end
        flash_status_host_pkg::ST_READ4: begin
          if (acc_done) begin
            if (tog_differs(first_r, last_r)) begin
              state_r <= flash_status_host_pkg::ST_RESET;
            end else begin
              result_r <= flash_status_host_pkg::RES_DONE;
              state_r  <= flash_status_host_pkg::ST_FINISH;
            end
          end
        end
        flash_status_host_pkg::ST_RESET: begin
          if (acc_done) begin
            result_r <= flash_status_host_pkg::RES_FAIL;
            state_r  <= flash_status_host_pkg::ST_FINISH;
          end
        end
        default: begin
          if (result_r == flash_status_host_pkg::RES_BUSY) begin
            result_r <= flash_status_host_pkg::RES_IDLE;
          end
          state_r <= flash_status_host_pkg::ST_IDLE;
        end
      endcase
      if ((state_r == flash_status_host_pkg::ST_READ1 ||
           state_r == flash_status_host_pkg::ST_READ2 ||
           state_r == flash_status_host_pkg::ST_READ3 ||
           state_r == flash_status_host_pkg::ST_READ4) &&
          acc_cnt_r == 4'(flash_status_host_pkg::ACC_CYC - 1)) begin
        last_r <= i_flash_dq; // Sampled just before the strobes rise, after the access time.
      end
    end
  end

  // Flash pin drive: reads use chip select plus output enable, the reset command uses write enable.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_flash_ce_n  <= 1'b1;
      o_flash_oe_n  <= 1'b1;
      o_flash_we_n  <= 1'b1;
      o_flash_dq_oe <= 1'b0;
      o_flash_dq    <= '0;
      o_flash_addr  <= '0;
    end else begin
      o_flash_ce_n  <= 1'b1;
      o_flash_oe_n  <= 1'b1;
      o_flash_we_n  <= 1'b1;
      o_flash_dq_oe <= 1'b0;
      if (acc_cnt_r < 4'(flash_status_host_pkg::ACC_CYC) && !acc_done) begin
        if (state_r == flash_status_host_pkg::ST_RESET) begin
          o_flash_ce_n  <= 1'b0;
          o_flash_we_n  <= 1'b0;
          o_flash_dq_oe <= 1'b1;
          o_flash_dq    <= flash_status_host_pkg::RESET_CMD_DATA;
          o_flash_addr  <= flash_status_host_pkg::RESET_CMD_ADDR;
        end else if (state_r == flash_status_host_pkg::ST_READ1 ||
                     state_r == flash_status_host_pkg::ST_READ2 ||
                     state_r == flash_status_host_pkg::ST_READ3 ||
                     state_r == flash_status_host_pkg::ST_READ4) begin
          o_flash_ce_n <= 1'b0;
          o_flash_oe_n <= 1'b0;
          o_flash_addr <= poll_addr_r;
        end
      end
    end
  end

  // Read data port, one cycle after the read strobe.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_sw_rdata <= '0;
      o_busy     <= 1'b0;
    end else begin
      o_busy <= (state_r != flash_status_host_pkg::ST_IDLE);
      if (i_sw_rd) begin
        if (i_sw_addr == flash_status_host_pkg::REG_ADDR) begin
          o_sw_rdata <= 32'(poll_addr_r);
        end else if (i_sw_addr == flash_status_host_pkg::REG_STATUS) begin
          o_sw_rdata <= {28'h0000000, ready_r, erase_timer_r, result_r};
        end else if (i_sw_addr == flash_status_host_pkg::REG_LAST) begin
          o_sw_rdata <= 32'(last_r);
        end else if (i_sw_addr == flash_status_host_pkg::REG_TOUT) begin
          o_sw_rdata <= tout_lim_r;
        end else begin
          o_sw_rdata <= 32'h00000000;
        end
      end else begin
        o_sw_rdata <= 32'h00000000;
      end
    end
  end
endmodule : flash_status_host

// ---- design/flash_status_host_pkg.sv ----
// Package with constants for the flash status polling host controller.
package flash_status_host_pkg;
  localparam int unsigned CLK_MHZ           = 50;
  localparam int unsigned TOUT_DEFAULT_US   = 20000;
  localparam int unsigned ADDR_W            = 20;
  localparam int unsigned DATA_W            = 16;
  localparam int unsigned SW_ADDR_W         = 4;
  localparam int unsigned ACC_CYC           = 6;
  localparam int unsigned GAP_CYC           = 2;
  localparam int unsigned ERASE_GAP_US      = 50;
  localparam int unsigned ERASE_GAP_CYC     = ERASE_GAP_US * CLK_MHZ;
  localparam logic [2:0]  DATA_POLL_POS     = 3'h7;
  localparam logic [2:0]  TOGGLE_POS        = 3'h6;
  localparam logic [2:0]  TIMEOUT_POS       = 3'h5;
  localparam logic [2:0]  ERASE_TIMER_POS   = 3'h3;
  localparam logic [2:0]  SECTOR_TOGGLE_POS = 3'h2;
  localparam logic [15:0] RESET_CMD_DATA    = 16'h00F0;
  localparam logic [ADDR_W-1:0] RESET_CMD_ADDR = 20'h00000;
  localparam logic [SW_ADDR_W-1:0] REG_CTRL    = 4'h0;
  localparam logic [SW_ADDR_W-1:0] REG_ADDR    = 4'h1;
  localparam logic [SW_ADDR_W-1:0] REG_STATUS  = 4'h2;
  localparam logic [SW_ADDR_W-1:0] REG_LAST    = 4'h3;
  localparam logic [SW_ADDR_W-1:0] REG_TOUT    = 4'h4;
  localparam logic [1:0]  RES_IDLE          = 2'h0;
  localparam logic [1:0]  RES_BUSY          = 2'h1;
  localparam logic [1:0]  RES_DONE          = 2'h2;
  localparam logic [1:0]  RES_FAIL          = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_READ1  = 3'h1,
    ST_READ2  = 3'h3,
    ST_CHECK  = 3'h2,
    ST_READ3  = 3'h6,
    ST_READ4  = 3'h7,
    ST_RESET  = 3'h5,
    ST_FINISH = 3'h4
  } poll_state_e;
endpackage : flash_status_host_pkg
